// [hdl/mcu_instruction_execute.sv]
// instruction execute core: pacing, prefetch, operand muxing and state
`timescale 1ns/1ps

// Overview of operation
// - program counter writes except branch clear bit 8
// - port read-modify-write uses pin levels
// - direction load copies accumulator to port direction latches
// - flagged timer writes clear timer-assigned prescaler
// - destination bit selects accumulator or file
// - add sets carry, digit carry, zero
// - bit clear/set touch no flags
// - test low skips when bit zero
// - test high skips when bit one
// - accumulator clear loads zero, sets zero flag
// - file clear writes zero, sets zero flag
// - call pushes, loads page, clears bit 8
// - branch loads nine bits plus page
// - watchdog kick clears counter, sets status bits
// - invert writes complement, updates zero flag
// - minus/plus one update only zero flag
// - skip variants flagless, skip on zero
// - literal and/or to accumulator, zero flag
// - file and/or to destination, zero flag
// - file move sets zero; store keeps flags
// - bank load takes three-bit literal
// - literal load and option load, no flags
// - instruction cycle is four clock periods
// - twelve-bit word split into operand fields
module mcu_instruction_execute
	import mcu_exec_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// program memory
	output logic [PC_W-1:0] prog_addr,
	input wire logic [INSTR_W-1:0] instr_word,
	// data file
	output logic [FILE_AW-1:0] file_addr,
	input wire logic [DATA_W-1:0] file_rdata,
	output logic [DATA_W-1:0] file_wdata,
	output logic file_we,
	// first port
	input wire logic [DATA_W-1:0] port_pins,
	output logic [DATA_W-1:0] port_dir,
	// special registers
	output logic [DATA_W-1:0] status_out,
	output logic [DATA_W-1:0] option_out,
	output logic [2:0] bank_select_latch,
	output logic [PC_W-1:0] stack_head,
	// timer and watchdog
	output logic prescaler_clear,
	output logic watchdog_clear,
	output logic cycle_strobe
);

	localparam int SP_W = $clog2(STACK_DEPTH);

	exec_if ex ();

	instr_decoder u_dec (
		.dx(ex.decoder)
	);

	exec_alu u_alu (
		.ax(ex.alu)
	);

	// ============================================================
	// pacing and pin synchroniser
	logic [1:0] phase_reg, phase_next;
	logic cyc_en;
	logic [DATA_W-1:0] pin_meta_reg, pin_sync_reg;

	assign cyc_en = phase_reg == LAST_PHASE;

	always_comb begin
		phase_next = phase_reg + 2'h1;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			phase_reg <= 2'h0;
			pin_meta_reg <= 8'h00;
			pin_sync_reg <= 8'h00;
		end else begin
			phase_reg <= phase_next;
			pin_meta_reg <= port_pins;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// ============================================================
	// execution state
	logic [PC_W-1:0] pc_reg, pc_next;
	logic [INSTR_W-1:0] ir_reg, ir_next;
	logic [DATA_W-1:0] w_reg, w_next;
	logic [DATA_W-1:0] status_reg, status_next;
	logic [DATA_W-1:0] option_reg, option_next;
	logic [DATA_W-1:0] dir_reg, dir_next;
	logic [2:0] bank_reg, bank_next;
	logic [PC_W-1:0] stack_reg [STACK_DEPTH];
	logic [PC_W-1:0] stack_next [STACK_DEPTH];
	logic [SP_W-1:0] sp_reg, sp_next;
	logic [DATA_W-1:0] wdata_reg, wdata_next;
	logic [FILE_AW-1:0] waddr_reg, waddr_next;
	logic we_reg, we_next;
	logic presc_clr_reg, presc_clr_next;
	logic wdt_clr_reg, wdt_clr_next;
	logic flush;
	logic [1:0] page;
	logic presc_on_wdt;

	assign page = status_reg[PAGE_HI:PAGE_LO];
	assign presc_on_wdt = option_reg[PRESC_WDT_BIT];
	assign ex.instr = ir_reg;
	assign ex.w = w_reg;

	always_comb begin
		// port reads see the pins, not the latch
		if (ex.f == PORT_ADDR) begin
			ex.fval = pin_sync_reg;
		end else if (ex.f == STATUS_ADDR) begin
			ex.fval = status_reg;
		end else if (ex.f == PCL_ADDR) begin
			ex.fval = pc_reg[7:0];
		end else begin
			ex.fval = file_rdata;
		end
	end

	always_comb begin
		pc_next = pc_reg;
		ir_next = ir_reg;
		w_next = w_reg;
		status_next = status_reg;
		option_next = option_reg;
		dir_next = dir_reg;
		bank_next = bank_reg;
		stack_next = stack_reg;
		sp_next = sp_reg;
		wdata_next = wdata_reg;
		waddr_next = waddr_reg;
		we_next = 1'b0;
		presc_clr_next = 1'b0;
		wdt_clr_next = 1'b0;
		flush = 1'b0;
		if (cyc_en) begin
			pc_next = pc_reg + 11'h001;
			if (ex.wr_w) begin
				w_next = ex.result;
			end
			if (ex.wr_f) begin
				if (ex.f == STATUS_ADDR) begin
					status_next = {ex.result[7:5], status_reg[TO_BIT:PD_BIT], ex.result[2:0]};
				end else if (ex.f == PCL_ADDR) begin
					pc_next = {page, 1'b0, ex.result};
					flush = 1'b1;
				end else begin
					we_next = 1'b1;
					wdata_next = ex.result;
					waddr_next = ex.f;
				end
			end
			if (ex.tmr_note && ex.f == TIMER_ADDR && !presc_on_wdt) begin
				presc_clr_next = 1'b1;
			end
			if (ex.z_upd) begin
				status_next[Z_BIT] = ex.z;
			end
			if (ex.c_upd) begin
				status_next[C_BIT] = ex.c;
			end
			if (ex.dc_upd) begin
				status_next[DC_BIT] = ex.dc;
			end
			unique case (ex.op)
				OP_CALL: begin
					stack_next[sp_reg] = pc_reg;
					sp_next = sp_reg + 1'b1;
					pc_next = {page, 1'b0, ex.k8};
					flush = 1'b1;
				end
				OP_BRANCH: begin
					pc_next = {page, ex.k9};
					flush = 1'b1;
				end
				OP_KICK_WDOG: begin
					wdt_clr_next = 1'b1;
					presc_clr_next = presc_on_wdt;
					status_next[TO_BIT] = 1'b1;
					status_next[PD_BIT] = 1'b1;
				end
				OP_OPTION: option_next = w_reg;
				OP_BANK: bank_next = ex.k8[2:0];
				OP_DIR_LOAD: dir_next = w_reg;
				default: begin
				end
			endcase
			if (ex.skip) begin
				flush = 1'b1;
			end
			// a discarded prefetch runs as an idle cycle
			ir_next = flush ? IDLE_WORD : instr_word;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pc_reg <= RESET_VECTOR;
			ir_reg <= IDLE_WORD;
			w_reg <= 8'h00;
			status_reg <= STATUS_RST;
			option_reg <= OPTION_RST;
			dir_reg <= DIR_RST;
			bank_reg <= BANK_RST;
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack_reg[i] <= 11'h000;
			end
			sp_reg <= '0;
			wdata_reg <= 8'h00;
			waddr_reg <= 5'h00;
			we_reg <= 1'b0;
			presc_clr_reg <= 1'b0;
			wdt_clr_reg <= 1'b0;
		end else begin
			pc_reg <= pc_next;
			ir_reg <= ir_next;
			w_reg <= w_next;
			status_reg <= status_next;
			option_reg <= option_next;
			dir_reg <= dir_next;
			bank_reg <= bank_next;
			stack_reg <= stack_next;
			sp_reg <= sp_next;
			wdata_reg <= wdata_next;
			waddr_reg <= waddr_next;
			we_reg <= we_next;
			presc_clr_reg <= presc_clr_next;
			wdt_clr_reg <= wdt_clr_next;
		end
	end

	// ============================================================
	// outputs
	assign prog_addr = pc_reg;
	// write pulse keeps the executed address, ir has moved on
	assign file_addr = we_reg ? waddr_reg : ir_reg[4:0];
	assign file_wdata = wdata_reg;
	assign file_we = we_reg;
	assign port_dir = dir_reg;
	assign status_out = status_reg;
	assign option_out = option_reg;
	assign bank_select_latch = bank_reg;
	assign stack_head = stack_reg[SP_W'(sp_reg - 1'b1)];
	assign prescaler_clear = presc_clr_reg;
	assign watchdog_clear = wdt_clr_reg;
	assign cycle_strobe = cyc_en;

	// ============================================================
	// assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	cycle_pace_a: assert property (cyc_en |=> !cyc_en [*3] ##1 cyc_en)
		else $error("instruction cycle is not four clocks");
	pcl_page_a: assert property (cyc_en && ex.wr_f && ex.f == PCL_ADDR
		|=> !pc_reg[8] && ir_reg == IDLE_WORD)
		else $error("program counter write left bit 8 set");
	port_pins_a: assert property (cyc_en && ex.wr_f && ex.f == PORT_ADDR
		&& ex.op == OP_MOVE_FILE |=> file_we && file_wdata == $past(pin_sync_reg))
		else $error("port rewrite did not use pin levels");
	dir_load_a: assert property (cyc_en && ex.op == OP_DIR_LOAD
		|=> port_dir == $past(w_reg))
		else $error("direction latch not loaded from accumulator");
	timer_presc_a: assert property (cyc_en && ex.tmr_note && ex.f == TIMER_ADDR
		&& !presc_on_wdt |=> prescaler_clear ##1 !prescaler_clear)
		else $error("timer write did not clear prescaler");
	dest_acc_a: assert property (cyc_en && ex.wr_w |=> w_reg == $past(ex.result)
		&& !file_we)
		else $error("accumulator destination missed");
	bit_flags_a: assert property (cyc_en && ex.op inside {OP_CLR_BIT, OP_SET_BIT}
		&& ex.f != STATUS_ADDR |=> status_reg == $past(status_reg))
		else $error("bit operation changed a flag");
	skip_idle_a: assert property (cyc_en && ex.skip
		|=> ir_reg == IDLE_WORD ##3 cyc_en)
		else $error("skip did not discard prefetch");
	null_acc_a: assert property (cyc_en && ex.op == OP_NULL_ACC
		|=> w_reg == 8'h00 && status_reg[Z_BIT])
		else $error("accumulator clear failed");
	call_load_a: assert property (cyc_en && ex.op == OP_CALL
		|=> pc_reg == {$past(page), 1'b0, $past(ir_reg[7:0])}
		&& stack_head == $past(pc_reg))
		else $error("call target or push wrong");
	branch_load_a: assert property (cyc_en && ex.op == OP_BRANCH
		|=> pc_reg == {$past(page), $past(ir_reg[8:0])})
		else $error("branch target wrong");
	kick_wdog_a: assert property (cyc_en && ex.op == OP_KICK_WDOG
		|=> watchdog_clear && status_reg[TO_BIT] && status_reg[PD_BIT])
		else $error("watchdog kick incomplete");
	bank_load_a: assert property (cyc_en && ex.op == OP_BANK
		|=> bank_select_latch == $past(ir_reg[2:0]))
		else $error("bank latch not loaded");
	idle_keep_a: assert property (cyc_en && ex.op == OP_IDLE
		|=> pc_reg == $past(pc_reg) + 11'h001 && w_reg == $past(w_reg)
		&& status_reg == $past(status_reg))
		else $error("idle instruction changed state");
	file_write_a: assert property (cyc_en && we_next
		|=> file_we && file_addr == $past(ex.f))
		else $error("file write went to the wrong address");

	call_seen_c: cover property (cyc_en && ex.op == OP_CALL);
	skip_taken_c: cover property (cyc_en && ex.skip);
	dir_load_c: cover property (cyc_en && ex.op == OP_DIR_LOAD);
	pcl_write_c: cover property (cyc_en && ex.wr_f && ex.f == PCL_ADDR);

endmodule

// [hdl/mcu_exec_pkg.sv]
// constants and types shared by the instruction execute block
package mcu_exec_pkg;

	// ============================================================
	// widths
	localparam int INSTR_W = 12;
	localparam int DATA_W = 8;
	localparam int PC_W = 11;
	localparam int FILE_AW = 5;
	localparam int STACK_DEPTH = 4;

	// ============================================================
	// pacing: oscillator periods per instruction cycle
	localparam int OSC_PER_CYCLE = 4;
	localparam logic [1:0] LAST_PHASE = 2'(OSC_PER_CYCLE - 1);

	// ============================================================
	// special file addresses
	localparam logic [FILE_AW-1:0] TIMER_ADDR = 5'h01;
	localparam logic [FILE_AW-1:0] PCL_ADDR = 5'h02;
	localparam logic [FILE_AW-1:0] STATUS_ADDR = 5'h03;
	localparam logic [FILE_AW-1:0] PORT_ADDR = 5'h05;

	// ============================================================
	// status field positions
	localparam int C_BIT = 0;
	localparam int DC_BIT = 1;
	localparam int Z_BIT = 2;
	localparam int PD_BIT = 3;
	localparam int TO_BIT = 4;
	localparam int PAGE_LO = 5;
	localparam int PAGE_HI = 6;

	// option field: 1 gives the prescaler to the watchdog
	localparam int PRESC_WDT_BIT = 3;

	// ============================================================
	// reset values and fixed words
	localparam logic [DATA_W-1:0] STATUS_RST = 8'h18;
	localparam logic [DATA_W-1:0] OPTION_RST = 8'hff;
	localparam logic [DATA_W-1:0] DIR_RST = 8'hff;
	localparam logic [2:0] BANK_RST = 3'h0;
	localparam logic [PC_W-1:0] RESET_VECTOR = 11'h000;
	localparam logic [INSTR_W-1:0] IDLE_WORD = 12'h000;

	// ============================================================
	// decoded operations
	typedef enum logic [4:0] {
		OP_IDLE, OP_STORE_ACC, OP_NULL_ACC, OP_NULL_FILE, OP_MINUS, OP_PLUS,
		OP_AND_FILE, OP_OR_FILE, OP_ADD_FILE, OP_MOVE_FILE, OP_INVERT,
		OP_MINUS_SKIP, OP_PLUS_SKIP, OP_CLR_BIT, OP_SET_BIT, OP_TEST_LOW,
		OP_TEST_HIGH, OP_AND_LIT, OP_OR_LIT, OP_LOAD_LIT, OP_CALL, OP_BRANCH,
		OP_KICK_WDOG, OP_OPTION, OP_BANK, OP_DIR_LOAD
	} op_t;

endpackage

// [hdl/exec_if.sv]
// carrier between the decoder, the arithmetic unit and the core
`timescale 1ns/1ps
interface exec_if;
	import mcu_exec_pkg::*;

	logic [INSTR_W-1:0] instr;
	op_t op;
	logic [FILE_AW-1:0] f;
	logic [2:0] b;
	logic [7:0] k8;
	logic [8:0] k9;
	logic wr_w;
	logic wr_f;
	logic tmr_note;
	logic [DATA_W-1:0] w;
	logic [DATA_W-1:0] fval;
	logic [DATA_W-1:0] result;
	logic z_upd;
	logic z;
	logic c_upd;
	logic c;
	logic dc_upd;
	logic dc;
	logic skip;

	modport decoder (input instr, output op, f, b, k8, k9, wr_w, wr_f, tmr_note);
	modport alu (input op, b, k8, w, fval, output result, z_upd, z, c_upd, c, dc_upd, dc, skip);
	modport core (output instr, w, fval,
		input op, f, b, k8, k9, wr_w, wr_f, tmr_note, result, z_upd, z, c_upd, c, dc_upd, dc,
		skip);
endinterface

// [hdl/instr_decoder.sv]
// splits the instruction word into operation and operand fields
`timescale 1ns/1ps
module instr_decoder
	import mcu_exec_pkg::*;
(
	exec_if.decoder dx
);

	logic byte_op;
	logic dest_sel;

	always_comb begin
		byte_op = 1'b0;
		dx.op = OP_IDLE;
		dest_sel = dx.instr[5];
		dx.f = dx.instr[4:0];
		dx.b = dx.instr[7:5];
		dx.k8 = dx.instr[7:0];
		dx.k9 = dx.instr[8:0];
		unique casez (dx.instr)
			12'b0000_0000_0000: dx.op = OP_IDLE;
			12'b0000_0000_0010: dx.op = OP_OPTION;
			12'b0000_0000_0100: dx.op = OP_KICK_WDOG;
			12'b0000_0000_0110: dx.op = OP_DIR_LOAD;
			12'b0000_0001_0???: dx.op = OP_BANK;
			12'b0000_001?_????: dx.op = OP_STORE_ACC;
			12'b0000_010?_????: dx.op = OP_NULL_ACC;
			12'b0000_011?_????: dx.op = OP_NULL_FILE;
			12'b0000_11??_????: begin dx.op = OP_MINUS; byte_op = 1'b1; end
			12'b0001_00??_????: begin dx.op = OP_OR_FILE; byte_op = 1'b1; end
			12'b0001_01??_????: begin dx.op = OP_AND_FILE; byte_op = 1'b1; end
			12'b0001_11??_????: begin dx.op = OP_ADD_FILE; byte_op = 1'b1; end
			12'b0010_00??_????: begin dx.op = OP_MOVE_FILE; byte_op = 1'b1; end
			12'b0010_01??_????: begin dx.op = OP_INVERT; byte_op = 1'b1; end
			12'b0010_10??_????: begin dx.op = OP_PLUS; byte_op = 1'b1; end
			12'b0010_11??_????: begin dx.op = OP_MINUS_SKIP; byte_op = 1'b1; end
			12'b0011_11??_????: begin dx.op = OP_PLUS_SKIP; byte_op = 1'b1; end
			12'b0100_????_????: dx.op = OP_CLR_BIT;
			12'b0101_????_????: dx.op = OP_SET_BIT;
			12'b0110_????_????: dx.op = OP_TEST_LOW;
			12'b0111_????_????: dx.op = OP_TEST_HIGH;
			12'b1001_????_????: dx.op = OP_CALL;
			12'b101?_????_????: dx.op = OP_BRANCH;
			12'b1100_????_????: dx.op = OP_LOAD_LIT;
			12'b1101_????_????: dx.op = OP_OR_LIT;
			12'b1110_????_????: dx.op = OP_AND_LIT;
			default: dx.op = OP_IDLE;
		endcase
		// destination bit picks accumulator or file
		dx.wr_w = (byte_op && !dest_sel) || dx.op inside {OP_NULL_ACC, OP_LOAD_LIT,
			OP_OR_LIT, OP_AND_LIT};
		dx.wr_f = (byte_op && dest_sel) || dx.op inside {OP_STORE_ACC, OP_NULL_FILE,
			OP_CLR_BIT, OP_SET_BIT};
		dx.tmr_note = dx.wr_f && dx.op != OP_INVERT;
	end

endmodule

// [hdl/exec_alu.sv]
// arithmetic and logic unit with flag and skip results
`timescale 1ns/1ps
module exec_alu
	import mcu_exec_pkg::*;
(
	exec_if.alu ax
);

	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] bit_mask;

	always_comb begin
		sum = {1'b0, ax.w} + {1'b0, ax.fval};
		nib = {1'b0, ax.w[3:0]} + {1'b0, ax.fval[3:0]};
		bit_mask = 8'h01 << ax.b;
		ax.result = 8'h00;
		ax.z_upd = 1'b0;
		ax.c_upd = 1'b0;
		ax.dc_upd = 1'b0;
		ax.skip = 1'b0;
		unique case (ax.op)
			OP_ADD_FILE: begin
				ax.result = sum[7:0];
				{ax.z_upd, ax.c_upd, ax.dc_upd} = 3'b111;
			end
			OP_AND_FILE: begin ax.result = ax.w & ax.fval; ax.z_upd = 1'b1; end
			OP_OR_FILE: begin ax.result = ax.w | ax.fval; ax.z_upd = 1'b1; end
			OP_AND_LIT: begin ax.result = ax.w & ax.k8; ax.z_upd = 1'b1; end
			OP_OR_LIT: begin ax.result = ax.w | ax.k8; ax.z_upd = 1'b1; end
			OP_INVERT: begin ax.result = ~ax.fval; ax.z_upd = 1'b1; end
			OP_MINUS: begin ax.result = ax.fval - 8'h01; ax.z_upd = 1'b1; end
			OP_PLUS: begin ax.result = ax.fval + 8'h01; ax.z_upd = 1'b1; end
			OP_MINUS_SKIP: begin
				ax.result = ax.fval - 8'h01;
				ax.skip = ax.result == 8'h00;
			end
			OP_PLUS_SKIP: begin
				ax.result = ax.fval + 8'h01;
				ax.skip = ax.result == 8'h00;
			end
			OP_MOVE_FILE: begin ax.result = ax.fval; ax.z_upd = 1'b1; end
			OP_STORE_ACC: ax.result = ax.w;
			OP_NULL_ACC, OP_NULL_FILE: ax.z_upd = 1'b1;
			OP_CLR_BIT: ax.result = ax.fval & ~bit_mask;
			OP_SET_BIT: ax.result = ax.fval | bit_mask;
			OP_TEST_LOW: ax.skip = !ax.fval[ax.b];
			OP_TEST_HIGH: ax.skip = ax.fval[ax.b];
			OP_LOAD_LIT: ax.result = ax.k8;
			default: ax.result = 8'h00;
		endcase
		ax.z = ax.result == 8'h00;
		ax.c = sum[8];
		ax.dc = nib[4];
	end

endmodule

// [tb/prog_file_model.sv]
// program memory and data file model facing the execute block
`timescale 1ns/1ps
module prog_file_model
	import mcu_exec_pkg::*;
(
	// clock
	input wire logic sys_clk,
	// program memory
	input wire logic [PC_W-1:0] prog_addr,
	output logic [INSTR_W-1:0] instr_word,
	// data file
	input wire logic [FILE_AW-1:0] file_addr,
	output logic [DATA_W-1:0] file_rdata,
	input wire logic [DATA_W-1:0] file_wdata,
	input wire logic file_we
);
	logic [INSTR_W-1:0] rom [0:2047];
	logic [DATA_W-1:0] ram [0:31];

	initial begin
		for (int i = 0; i < 2048; i++) begin
			rom[i] = IDLE_WORD;
		end
		for (int i = 0; i < 32; i++) begin
			ram[i] = 8'h00;
		end
	end

	// ============================================================
	// fetch and file access
	assign instr_word = rom[prog_addr];
	assign file_rdata = ram[file_addr];

	always @(posedge sys_clk) begin
		if (file_we) begin
			ram[file_addr] <= file_wdata;
		end
	end
endmodule

// [tb/mcu_instruction_execute_tb_top.sv]
// self-checking bench for the instruction execute block
`timescale 1ns/1ps
module mcu_instruction_execute_tb_top;
	import mcu_exec_pkg::*;

	typedef struct packed {
		logic [11:0] op;
		logic [7:0] w;
		logic [7:0] f;
		logic [7:0] ef;
		logic [7:0] ew;
		logic [2:0] fl;
		logic sk;
	} row_t;

	logic sys_clk;
	logic rst_n;
	logic [PC_W-1:0] prog_addr;
	logic [INSTR_W-1:0] instr_word;
	logic [FILE_AW-1:0] file_addr;
	logic [DATA_W-1:0] file_rdata;
	logic [DATA_W-1:0] file_wdata;
	logic file_we;
	logic [DATA_W-1:0] port_pins;
	logic [DATA_W-1:0] port_dir;
	logic [DATA_W-1:0] status_out;
	logic [DATA_W-1:0] option_out;
	logic [2:0] bank_select_latch;
	logic [PC_W-1:0] stack_head;
	logic prescaler_clear;
	logic watchdog_clear;
	logic cycle_strobe;
	int n_fail = 0;
	int comparisons = 0;
	int n_strobe = 0;
	int n_wd = 0;
	int n_ps = 0;

	// ============================================================
	// ordinary cases: op, w, f, file after, w after, flags z-dc-c, skip
	row_t rows [0:23] = '{
		'{12'h1e8, 8'h0f, 8'h01, 8'h10, 8'h0f, 3'h2, 1'b0},
		'{12'h1c8, 8'h80, 8'h80, 8'h80, 8'h00, 3'h5, 1'b0},
		'{12'h148, 8'hf0, 8'h3c, 8'h3c, 8'h30, 3'h0, 1'b0},
		'{12'h128, 8'h00, 8'h00, 8'h00, 8'h00, 3'h4, 1'b0},
		'{12'h068, 8'h12, 8'h55, 8'h00, 8'h12, 3'h4, 1'b0},
		'{12'h040, 8'h77, 8'h55, 8'h55, 8'h00, 3'h4, 1'b0},
		'{12'h268, 8'h33, 8'hff, 8'h00, 8'h33, 3'h4, 1'b0},
		'{12'h0c8, 8'h33, 8'h01, 8'h01, 8'h00, 3'h4, 1'b0},
		'{12'h2a8, 8'h33, 8'hff, 8'h00, 8'h33, 3'h4, 1'b0},
		'{12'h208, 8'h33, 8'h00, 8'h00, 8'h00, 3'h4, 1'b0},
		'{12'h028, 8'ha5, 8'h00, 8'ha5, 8'ha5, 3'h0, 1'b0},
		'{12'h4e8, 8'h00, 8'hff, 8'h7f, 8'h00, 3'h0, 1'b0},
		'{12'h508, 8'h00, 8'h00, 8'h01, 8'h00, 3'h0, 1'b0},
		'{12'he0f, 8'hf0, 8'h55, 8'h55, 8'h00, 3'h4, 1'b0},
		'{12'hd5a, 8'h00, 8'h55, 8'h55, 8'h5a, 3'h0, 1'b0},
		'{12'hc3c, 8'h99, 8'h55, 8'h55, 8'h3c, 3'h0, 1'b0},
		'{12'h000, 8'h3c, 8'h3c, 8'h3c, 8'h3c, 3'h0, 1'b0},
		'{12'h2e8, 8'h44, 8'h01, 8'h00, 8'h44, 3'h0, 1'b1},
		'{12'h3c8, 8'h44, 8'hff, 8'hff, 8'h00, 3'h0, 1'b1},
		'{12'h3e8, 8'h44, 8'h10, 8'h11, 8'h44, 3'h0, 1'b0},
		'{12'h668, 8'h44, 8'hf7, 8'hf7, 8'h44, 3'h0, 1'b1},
		'{12'h668, 8'h44, 8'h08, 8'h08, 8'h44, 3'h0, 1'b0},
		'{12'h768, 8'h44, 8'h08, 8'h08, 8'h44, 3'h0, 1'b1},
		'{12'h768, 8'h44, 8'hf7, 8'hf7, 8'h44, 3'h0, 1'b0}
	};

	// direction, bank, option, kicks, timer store, port rmw, page set, call
	logic [11:0] prog_b [0:13] = '{12'hc5a, 12'h006, 12'h015, 12'hc08, 12'h002,
		12'h004, 12'hc00, 12'h002, 12'h004, 12'h021, 12'h225, 12'hc60, 12'h023, 12'h945};

	mcu_instruction_execute dut_u (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.prog_addr(prog_addr),
		.instr_word(instr_word),
		.file_addr(file_addr),
		.file_rdata(file_rdata),
		.file_wdata(file_wdata),
		.file_we(file_we),
		.port_pins(port_pins),
		.port_dir(port_dir),
		.status_out(status_out),
		.option_out(option_out),
		.bank_select_latch(bank_select_latch),
		.stack_head(stack_head),
		.prescaler_clear(prescaler_clear),
		.watchdog_clear(watchdog_clear),
		.cycle_strobe(cycle_strobe)
	);

	prog_file_model mem_u (
		.sys_clk(sys_clk),
		.prog_addr(prog_addr),
		.instr_word(instr_word),
		.file_addr(file_addr),
		.file_rdata(file_rdata),
		.file_wdata(file_wdata),
		.file_we(file_we)
	);

	initial begin
		sys_clk = 1'b0;
	end

	always #50 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		if (cycle_strobe) n_strobe++;
		if (watchdog_clear) n_wd++;
		if (prescaler_clear) n_ps++;
	end

	// ============================================================
	// shared tasks
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic wait_addr(input logic [10:0] a);
		int n;
		n = 0;
		while (prog_addr !== a && n < 200) begin
			@(posedge sys_clk);
			n++;
		end
	endtask

	task automatic run_row(input row_t r);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		mem_u.rom[0] = 12'hc00 | 12'(r.w);
		mem_u.rom[1] = r.op;
		mem_u.rom[2] = 12'h030;
		mem_u.rom[3] = 12'h031;
		mem_u.ram[8] = r.f;
		mem_u.ram[16] = 8'hee;
		mem_u.ram[17] = 8'hee;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (30) @(posedge sys_clk);
		#1;
		check(12'(mem_u.ram[8]), 12'(r.ef));
		check(12'(mem_u.ram[17]), 12'(r.ew));
		check(12'(mem_u.ram[16]), 12'(r.sk ? 8'hee : r.ew));
		check(12'(status_out[2:0]), 12'(r.fl));
	endtask

	// ============================================================
	// main sequence
	initial begin
		rst_n <= 1'b0;
		port_pins <= 8'h00;
		repeat (8) @(posedge sys_clk);
		#1;
		check(12'(status_out), 12'(STATUS_RST));
		check(12'(option_out), 12'(OPTION_RST));
		check(12'(port_dir), 12'(DIR_RST));
		check(12'(bank_select_latch), 12'(BANK_RST));
		check(12'(prog_addr), 12'(RESET_VECTOR));
		foreach (rows[i]) begin
			run_row(rows[i]);
		end
		@(posedge sys_clk);
		rst_n <= 1'b0;
		port_pins <= 8'h0f;
		for (int i = 0; i < 14; i++) begin
			mem_u.rom[i] = prog_b[i];
		end
		mem_u.rom[12'h645] = 12'hbfe;
		mem_u.rom[12'h7fe] = 12'h022;
		mem_u.ram[5] = 8'hff;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		#1;
		check(12'(prog_addr), 12'(RESET_VECTOR));
		n_strobe = 0;
		n_wd = 0;
		n_ps = 0;
		repeat (40) @(posedge sys_clk);
		check(12'(n_strobe), 12'd10);
		wait_addr(11'h645);
		#1;
		check(12'(prog_addr), 12'h645);
		check(12'(prog_addr[8]), 12'h000);
		check(12'(stack_head), 12'h00e);
		check(12'(status_out[6:5]), 12'h003);
		wait_addr(11'h7fe);
		#1;
		check(12'(prog_addr), 12'h7fe);
		wait_addr(11'h660);
		#1;
		check(12'(prog_addr), 12'h660);
		repeat (8) @(posedge sys_clk);
		#1;
		check(12'(port_dir), 12'h05a);
		check(12'(bank_select_latch), 12'h005);
		check(12'(option_out), 12'h000);
		check(12'(n_wd), 12'd2);
		check(12'(n_ps), 12'd2);
		check(12'(mem_u.ram[5]), 12'h00f);
		check(12'(status_out[4:3]), 12'h003);
		finish_test();
	end

	// ============================================================
	// hang guard
	initial begin
		#3000000;
		n_fail++;
		finish_test();
	end
endmodule
